// >>> rtl/dec_accum.sv
// decimal digit accumulator: value = value * 10 + digit
// assumes digits arrive one per enabled cycle; overflow wraps silently
module dec_accum #(
    parameter int W = 24
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rst,     // async reset, active high
    input  wire logic         clr,     // restart at zero
    input  wire logic         en,      // take one digit
    input  wire logic [3:0]   digit,   // digit value 0..9
    output logic      [W-1:0] value    // accumulated value
);
    logic [W-1:0] acc_q;
    logic [W-1:0] acc_d;

    // clear wins, a new frame never inherits digits
    always_comb begin
        acc_d = acc_q;
        if (clr) begin
            acc_d = '0;
        end else if (en) begin
            acc_d = W'(acc_q * W'(10) + W'(digit));
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign value = acc_q;
endmodule

// >>> rtl/serial_cmd_core.sv
// serial remote command interpreter: frame parser, command dispatch, reply
// assumes byte-level rx/tx outside, an application that answers read commands
// with a byte stream, and an external store that keeps the settings
//
// Contract
// - frame is address, command, space, parameter, then carriage return
// - every read reply ends with a line feed
// - transmit only while answering a read query, never unsolicited
// - commands split into read type and write type
// - write commands applied only in remote mode
// - on RS485 an A plus three digits precedes each command
// - parameters are decimal text with a period separator
// - selecting remote mode enters remote stop and shows it
// - interface settings kept in non-volatile storage
// - setpoints taken only when setpoint source matches the link type
module serial_cmd_core #(
    parameter int DROP_W = 8
) (
    input  wire logic                      sys_clk,     // 250 MHz clock
    input  wire logic                      rst,         // async reset, active high
    input  wire logic [3:0]                reg_addr,    // register byte address
    input  wire logic [31:0]               reg_wdata,   // register write data
    input  wire logic                      reg_wr,      // write strobe
    input  wire logic                      reg_rd,      // read strobe
    output logic      [31:0]               reg_rdata,   // read data, cycle after
    input  wire serial_cmd_pkg::byte_t     rx_i,        // received byte
    output serial_cmd_pkg::byte_t          tx_o,        // byte to transmit
    input  wire logic                      tx_ready,    // transmitter takes byte
    input  wire serial_cmd_pkg::resp_t     resp_i,      // reply bytes from app
    output logic                           resp_ready,  // reply byte taken
    output serial_cmd_pkg::cmd_t           cmd_o,       // command from the last complete frame
    output logic                           wr_stb,      // write command pulse
    output logic                           rd_stb,      // read command pulse
    output logic                           remote_stop, // remote stop shown
    output serial_cmd_pkg::cfg_t           nv_cfg,      // settings to store
    output logic                           nv_save,     // store request pulse
    input  wire logic                      nv_load,     // restore pulse
    input  wire serial_cmd_pkg::cfg_t      nv_cfg_in    // settings from store
);
    import serial_cmd_pkg::*;

    parse_state_t      st_q, st_d;
    logic [WORD_LEN*8-1:0] word_q, word_d;
    logic [3:0]        len_q, len_d;
    logic              neg_q, neg_d, point_q, point_d, seen_q, seen_d;
    logic [1:0]        frac_q, frac_d, adig_q, adig_d;
    logic [2:0]        pidx_q, pidx_d;
    logic [DROP_W-1:0] drops_q, drops_d;
    logic              open_q, open_d, wr_q, wr_d, rd_q, rd_d, rr_q, rr_d;
    logic              stop_q, stop_d, rsel_q, save_q, save_d;
    byte_t             tx_q, tx_d;
    cmd_t              cmd_q, cmd_d;
    cfg_t              cfg_q, cfg_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              acc_clr, acc_en, adr_en, bad, is_dig, addr_ok;
    logic              is_out, is_in, is_sp, is_start, sp_ok;
    logic [VAL_W-1:0]  acc_val, scaled;
    logic [9:0]        adr_val;
    logic [7:0]        pfx_char;

    // parameter digits and address digits share one accumulator design
    dec_accum #(.W(VAL_W)) u_param (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clr     (acc_clr),
        .en      (acc_en),
        .digit   (rx_i.data[3:0]),
        .value   (acc_val)
    );
    dec_accum #(.W(10)) u_addr (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clr     (acc_clr),
        .en      (adr_en),
        .digit   (rx_i.data[3:0]),
        .value   (adr_val)
    );

    // command classification from the stored word
    always_comb begin
        is_dig   = (rx_i.data >= CH_ZERO) && (rx_i.data <= CH_NINE);
        is_out   = word_q[WORD_LEN*8-1 -: 24] == "OUT";
        is_in    = word_q[WORD_LEN*8-1 -: 16] == "IN";
        is_sp    = word_q[WORD_LEN*8-1 -: 48] == "OUT_SP";
        is_start = (word_q[WORD_LEN*8-1 -: 88] == "OUT_MODE_05") && (len_q == 4'hB);
        // setpoint source must match the link
        sp_ok    = !is_sp || (cfg_q.sp_serial && (cfg_q.sp_485 == cfg_q.link_485));
        addr_ok  = !cfg_q.link_485 || (adr_val == cfg_q.instrument_bus_address);
        // fixed point in hundredths, period gives fraction digits
        unique case (frac_q)
            2'h0:    scaled = VAL_W'(acc_val * VAL_W'(100));
            2'h1:    scaled = VAL_W'(acc_val * VAL_W'(10));
            default: scaled = acc_val;
        endcase
        unique case (pidx_q)
            3'h0:    pfx_char = CH_ADDR;
            3'h1:    pfx_char = CH_ZERO | 8'(cfg_q.instrument_bus_address / 10'd100);
            3'h2:    pfx_char = CH_ZERO | 8'((cfg_q.instrument_bus_address / 10'd10) % 10'd10);
            3'h3:    pfx_char = CH_ZERO | 8'(cfg_q.instrument_bus_address % 10'd10);
            default: pfx_char = CH_UNDER;
        endcase
    end

    // frame parser, dispatch and reply sequencing
    always_comb begin
        st_d = st_q; word_d = word_q; len_d = len_q; neg_d = neg_q;
        point_d = point_q; seen_d = seen_q; frac_d = frac_q; adig_d = adig_q;
        pidx_d = pidx_q; drops_d = drops_q; open_d = open_q; cmd_d = cmd_q;
        wr_d = 1'b0; rd_d = 1'b0; acc_clr = 1'b0; acc_en = 1'b0; adr_en = 1'b0;
        bad = 1'b0;
        tx_d = tx_q;
        tx_d.valid = tx_q.valid && !tx_ready;
        unique case (st_q)
            // a frame starts with address or command word
            S_IDLE: if (rx_i.valid && rx_i.data != CH_CR) begin
                acc_clr = 1'b1; word_d = '0; len_d = 4'h0; neg_d = 1'b0;
                point_d = 1'b0; seen_d = 1'b0; frac_d = 2'h0; adig_d = 2'h0;
                // RS485 frames open with the address letter
                if (cfg_q.link_485) begin
                    if (rx_i.data == CH_ADDR) st_d = S_ADDR;
                    else bad = 1'b1;
                end else if (rx_i.data == CH_SPACE) begin
                    bad = 1'b1;
                end else begin
                    word_d[WORD_LEN*8-1 -: 8] = rx_i.data;
                    len_d = 4'h1;
                    st_d = S_WORD;
                end
            end
            S_ADDR: if (rx_i.valid) begin
                if (is_dig) begin
                    adr_en = 1'b1;
                    adig_d = adig_q + 2'h1;
                    if (adig_q == 2'(ADDR_DIGS - 1)) st_d = S_SEP;
                end else bad = 1'b1;
            end
            S_SEP: if (rx_i.valid) begin
                if (rx_i.data == CH_UNDER) st_d = S_WORD;
                else bad = 1'b1;
            end
            S_WORD: if (rx_i.valid) begin
                if (rx_i.data == CH_CR && len_q != 4'h0) st_d = S_EXEC;
                else if (rx_i.data == CH_SPACE && len_q != 4'h0) st_d = S_PARAM;
                else if (rx_i.data == CH_CR || rx_i.data == CH_SPACE) bad = 1'b1;
                else if (len_q == 4'(WORD_LEN)) bad = 1'b1;
                else begin
                    word_d[8*(WORD_LEN-1-int'(len_q)) +: 8] = rx_i.data;
                    len_d = len_q + 4'h1;
                end
            end
            // optional sign, digits, one period, up to two fraction digits
            S_PARAM: if (rx_i.valid) begin
                if (rx_i.data == CH_CR) begin
                    if (seen_q) st_d = S_EXEC;
                    else bad = 1'b1;
                end else if (rx_i.data == CH_MINUS && !seen_q && !neg_q && !point_q) begin
                    neg_d = 1'b1;
                end else if (rx_i.data == CH_POINT && !point_q) begin
                    point_d = 1'b1;
                end else if (is_dig && !(point_q && frac_q == FRAC_MAX)) begin
                    acc_en = 1'b1;
                    seen_d = 1'b1;
                    if (point_q) frac_d = frac_q + 2'h1;
                end else bad = 1'b1;
            end
            // wait for the terminator before listening again
            S_SKIP: if (rx_i.valid && rx_i.data == CH_CR) st_d = S_IDLE;
            S_EXEC: begin
                st_d = S_IDLE;
                cmd_d = '{word_q, len_q, seen_q, neg_q ? VAL_W'(-scaled) : scaled};
                if (!addr_ok) begin
                    st_d = S_IDLE;
                end else if (is_out && seen_q) begin
                    wr_d = cfg_q.remote_sel && sp_ok;
                end else if (is_in) begin
                    // a reply is opened only by a read query
                    rd_d = 1'b1;
                    open_d = 1'b1;
                    pidx_d = 3'h0;
                    st_d = cfg_q.link_485 ? S_PFX : S_REPLY;
                end else begin
                    drops_d = drops_q + 1'b1;
                end
            end
            // RS485 reply carries own address and an underscore
            S_PFX: if (!tx_d.valid) begin
                tx_d = '{1'b1, pfx_char};
                pidx_d = pidx_q + 3'h1;
                if (pidx_q == 3'h4) st_d = S_REPLY;
            end
            S_REPLY: if (resp_i.valid && rr_q) begin
                tx_d = '{1'b1, resp_i.data};
                if (resp_i.last) st_d = S_LF;
            end
            S_LF: if (!tx_d.valid) begin
                tx_d = '{1'b1, CH_LF};
                st_d = S_IDLE;
            end
        endcase
        // bad byte drops the frame, a CR resyncs at once
        if (bad) begin
            drops_d = drops_q + 1'b1;
            st_d = (rx_i.data == CH_CR) ? S_IDLE : S_SKIP;
        end
        if (tx_q.valid && tx_ready && tx_q.data == CH_LF && st_q != S_REPLY && st_q != S_PFX)
            open_d = 1'b0;
        rr_d = (st_d == S_REPLY) && !tx_d.valid;
    end

    // settings, remote stop and register bus
    always_comb begin
        cfg_d = cfg_q;
        save_d = 1'b0;
        // restore from and save to the external store
        if (nv_load) cfg_d = nv_cfg_in;
        if (reg_wr && reg_addr == REG_CTRL) begin
            cfg_d.remote_sel = reg_wdata[CTRL_REMOTE];
            cfg_d.link_485   = reg_wdata[CTRL_LINK];
            cfg_d.sp_serial  = reg_wdata[CTRL_SPSER];
            cfg_d.sp_485     = reg_wdata[CTRL_SPLINK];
            save_d = 1'b1;
        end
        if (reg_wr && reg_addr == REG_ADDR) begin
            cfg_d.instrument_bus_address = reg_wdata[9:0];
            save_d = 1'b1;
        end
        // entering remote mode lands in remote stop
        stop_d = stop_q;
        if (!cfg_q.remote_sel) stop_d = 1'b0;
        else if (!rsel_q) stop_d = 1'b1;
        else if (wr_d && is_start) stop_d = (scaled == '0);
        // unmapped offsets read zero; data only in the cycle after the strobe
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: rdata_d = 32'({cfg_q.sp_485, cfg_q.sp_serial,
                                         cfg_q.link_485, cfg_q.remote_sel});
                REG_ADDR: rdata_d = 32'(cfg_q.instrument_bus_address);
                REG_STAT: rdata_d = 32'({cfg_q.remote_sel, open_q, stop_q});
                REG_DROP: rdata_d = 32'(drops_q);
                default:  rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE; word_q <= '0; len_q <= 4'h0; neg_q <= 1'b0;
            point_q <= 1'b0; seen_q <= 1'b0; frac_q <= 2'h0; adig_q <= 2'h0;
            pidx_q <= 3'h0; drops_q <= '0; open_q <= 1'b0; wr_q <= 1'b0;
            rd_q <= 1'b0; rr_q <= 1'b0; stop_q <= 1'b0; rsel_q <= 1'b0;
            save_q <= 1'b0; tx_q <= '0; cmd_q <= '0; cfg_q <= CFG_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d; word_q <= word_d; len_q <= len_d; neg_q <= neg_d;
            point_q <= point_d; seen_q <= seen_d; frac_q <= frac_d; adig_q <= adig_d;
            pidx_q <= pidx_d; drops_q <= drops_d; open_q <= open_d; wr_q <= wr_d;
            rd_q <= rd_d; rr_q <= rr_d; stop_q <= stop_d; rsel_q <= cfg_q.remote_sel;
            save_q <= save_d; tx_q <= tx_d; cmd_q <= cmd_d; cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata   = rdata_q;
    assign tx_o        = tx_q;
    assign resp_ready  = rr_q;
    assign cmd_o       = cmd_q;
    assign wr_stb      = wr_q;
    assign rd_stb      = rd_q;
    assign remote_stop = stop_q;
    assign nv_cfg      = cfg_q;
    assign nv_save     = save_q;

    // checks on the parser, reply path, remote mode and settings restore
    a_exec_after_cr: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_EXEC |-> $past(rx_i.valid) && $past(rx_i.data) == CH_CR)
        else $error("command executed without terminator");
    a_lf_closes_reply: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_LF && (!tx_q.valid || tx_ready) |=> tx_o.valid && tx_o.data == CH_LF)
        else $error("reply not closed by line feed");
    a_tx_only_reply: assert property (@(posedge sys_clk) disable iff (rst)
        tx_o.valid |-> open_q)
        else $error("unsolicited transmit");
    a_class_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
        !(wr_stb && rd_stb) &&
        (!wr_stb || cmd_o.word[WORD_LEN*8-1 -: 24] == "OUT") &&
        (!rd_stb || cmd_o.word[WORD_LEN*8-1 -: 16] == "IN"))
        else $error("command class mismatch");
    a_write_remote: assert property (@(posedge sys_clk) disable iff (rst)
        wr_stb |-> $past(cfg_q.remote_sel))
        else $error("write applied outside remote mode");
    a_remote_entry: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cfg_q.remote_sel) |=> remote_stop)
        else $error("remote stop not entered");
    a_nv_restore: assert property (@(posedge sys_clk) disable iff (rst)
        nv_load && !reg_wr |=> nv_cfg == $past(nv_cfg_in))
        else $error("settings not restored");
    a_sp_source: assert property (@(posedge sys_clk) disable iff (rst)
        wr_stb && cmd_o.word[WORD_LEN*8-1 -: 48] == "OUT_SP" |->
        $past(cfg_q.sp_serial && cfg_q.sp_485 == cfg_q.link_485))
        else $error("setpoint taken from wrong source");
    a_addr_prefix: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_PFX && pidx_q == 3'h0 && !tx_q.valid |=> tx_o.data == CH_ADDR)
        else $error("reply prefix missing");
    a_skip_silent: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == S_SKIP && rx_i.valid && rx_i.data == CH_CR |=> st_q == S_IDLE ##1 !wr_stb)
        else $error("dropped frame acted upon");

    c_write_taken: cover property (@(posedge sys_clk) disable iff (rst) wr_stb);
    c_reply_done: cover property (@(posedge sys_clk) disable iff (rst)
        tx_o.valid && tx_ready && tx_o.data == CH_LF);
    c_frame_dropped: cover property (@(posedge sys_clk) disable iff (rst)
        st_q == S_SKIP ##1 st_q == S_IDLE);
endmodule

// >>> rtl/serial_cmd_pkg.sv
// constants and carrier types for the serial remote command interpreter
// assumes a byte-level receiver and transmitter outside (no bit timing here)
package serial_cmd_pkg;
    // frame characters
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_POINT = 8'h2E;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_UNDER = 8'h5F;
    localparam logic [7:0] CH_ADDR  = 8'h41;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_NINE  = 8'h39;

    // command word storage and parameter format
    localparam int         WORD_LEN  = 12;
    localparam int         VAL_W     = 24;
    localparam int         ADDR_DIGS = 3;
    localparam logic [1:0] FRAC_MAX  = 2'h2;

    // register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_DROP = 4'hC;

    // control and status register fields
    localparam int CTRL_REMOTE = 0;
    localparam int CTRL_LINK   = 1;
    localparam int CTRL_SPSER  = 2;
    localparam int CTRL_SPLINK = 3;
    localparam int STAT_STOP   = 0;
    localparam int STAT_OPEN   = 1;
    localparam int STAT_REMOTE = 2;

    typedef struct packed {
        logic       remote_sel;
        logic       link_485;
        logic       sp_serial;
        logic       sp_485;
        logic [9:0] instrument_bus_address;
    } cfg_t;

    localparam cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 10'h000};

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } resp_t;

    typedef struct packed {
        logic [WORD_LEN*8-1:0] word;
        logic [3:0]            len;
        logic                  has_param;
        logic [VAL_W-1:0]      value;
    } cmd_t;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_SEP, S_WORD, S_PARAM, S_SKIP, S_EXEC, S_PFX, S_REPLY, S_LF
    } parse_state_t;
endpackage

// >>> test/host_model.sv
// host side model: takes the bytes the device transmits, may stall it
// assumes byte-level transfers; the bench reads the captured bytes
module host_model (
    input  wire logic                  sys_clk,  // system clock
    input  wire logic                  rst,      // async reset, active high
    input  wire serial_cmd_pkg::byte_t tx,       // byte offered by the device
    input  wire logic                  slow,     // stall every other cycle
    output logic                       tx_ready  // byte accepted
);
    import serial_cmd_pkg::*;

    logic [7:0] got [$];

    // reply capture: every accepted byte is logged
    // logging everything lets the bench spot unsolicited bytes
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx.valid && tx_ready)
                got.push_back(tx.data);
        end
    end
endmodule

// >>> test/tb.sv
// self-checking bench for the serial command interpreter
// assumes the design package and host_model are compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_cmd_pkg::*;

    logic        sys_clk, rst, reg_wr, reg_rd, tx_ready, resp_ready;
    logic        wr_stb, rd_stb, remote_stop, nv_save, nv_load, slow;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    byte_t       rx_i, tx_o;
    resp_t       resp_i;
    cmd_t        cmd_o;
    cfg_t        nv_cfg, nv_cfg_in;
    int          miscompares = 0;
    int          tests_run = 0;
    int          n_wr = 0;
    int          n_rd = 0;
    int          n_save = 0;

    serial_cmd_core DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_i(rx_i), .tx_o(tx_o), .tx_ready(tx_ready), .resp_i(resp_i),
        .resp_ready(resp_ready), .cmd_o(cmd_o), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .remote_stop(remote_stop), .nv_cfg(nv_cfg), .nv_save(nv_save),
        .nv_load(nv_load), .nv_cfg_in(nv_cfg_in));
    host_model host (.sys_clk(sys_clk), .rst(rst), .tx(tx_o), .slow(slow),
        .tx_ready(tx_ready));

    // clock source
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // pulse counters; one count per registered pulse
    always @(posedge sys_clk) begin
        if (wr_stb === 1'b1) n_wr++;
        if (rd_stb === 1'b1) n_rd++;
        if (nv_save === 1'b1) n_save++;
    end

    task automatic chk(string name, logic [95:0] seen, logic [95:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic reg_write(logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // frame out: one byte per clock, then the terminator
    task automatic send(string s);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge sys_clk);
            rx_i <= '{1'b1, s[i]};
        end
        @(posedge sys_clk);
        rx_i <= '{1'b1, CH_CR};
        @(posedge sys_clk);
        rx_i <= '{1'b0, 8'h00};
        // host gap, scaled down from milliseconds
        cyc(40);
    endtask

    // each reply byte held until taken, then what the host saw is compared
    task automatic reply(string r, string exp, int base);
        int k;
        logic [95:0] v;
        logic [95:0] e;
        v = '0;
        e = '0;
        for (int i = 0; i < r.len(); i++) begin
            resp_i <= '{1'b1, i == r.len() - 1, r[i]};
            k = 0;
            do begin
                @(posedge sys_clk);
                k++;
            end while (resp_ready !== 1'b1 && k < 100);
        end
        resp_i <= '{1'b0, 1'b0, 8'h00};
        k = 0;
        while (host.got.size() < base + exp.len() && k < 500) begin
            cyc(1);
            k++;
        end
        cyc(10);
        for (int i = base; i < host.got.size(); i++) v = {v[87:0], host.got[i]};
        for (int i = 0; i < exp.len(); i++) e = {e[87:0], exp[i]};
        chk("reply", v, e);
        cyc(20);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        reg_read(REG_STAT, d);
        chk("stat_rst", d, 32'h0);
        reg_read(4'h2, d);
        chk("unmapped", d, 32'h0);
        reg_write(4'h2, 32'hFFFFFFFF);
        reg_write(REG_CTRL, 32'h00000001);
        cyc(3);
        chk("nv_save", n_save, 1);
        chk("remote_stop", remote_stop, 1);
        reg_read(REG_STAT, d);
        chk("stat", d, 32'h00000005);
    endtask

    task automatic t_write();
        int n;
        reg_write(REG_CTRL, 32'h00000005);
        n = host.got.size();
        send("OUT_SP_00 55.5");
        chk("wr_count", n_wr, 1);
        chk("word", cmd_o.word, {"OUT_SP_00", 24'h000000});
        chk("value", cmd_o.value, 24'h0015AE);
        send("OUT_MODE_05 1");
        chk("start", remote_stop, 0);
        chk("rd_none", n_rd, 0);
        chk("no_tx", host.got.size(), n);
    endtask

    task automatic t_block();
        reg_write(REG_CTRL, 32'h00000004);
        send("OUT_SP_00 1");
        chk("wr_local", n_wr, 2);
        reg_write(REG_CTRL, 32'h0000000D);
        send("OUT_SP_00 1");
        chk("wr_source", n_wr, 2);
        send("OUT_MODE_05 1");
        chk("wr_mode", n_wr, 3);
    endtask

    // slow host stalls the transmitter during the reply
    task automatic t_read();
        int n;
        reg_write(REG_CTRL, 32'h00000005);
        slow <= 1'b1;
        n = host.got.size();
        send("IN_SP_00");
        chk("rd_count", n_rd, 1);
        reply("55.5", "55.5\n", n);
        slow <= 1'b0;
    endtask

    task automatic t_485();
        logic [31:0] d;
        logic [31:0] e;
        int n;
        @(posedge sys_clk);
        nv_cfg_in <= '{1'b1, 1'b1, 1'b1, 1'b1, 10'h020};
        nv_load <= 1'b1;
        @(posedge sys_clk);
        nv_load <= 1'b0;
        cyc(2);
        chk("restore", nv_cfg, {4'hF, 10'h020});
        send("A031_IN_SP_00");
        chk("foreign", n_rd, 1);
        // the prefix leaves during the host gap, so count from before the query
        n = host.got.size();
        send("A032_IN_SP_00");
        chk("own", n_rd, 2);
        reply("7", "A032_7\n", n);
        reg_read(REG_DROP, d);
        send("A032_OUT_SP_00 5.5.5");
        reg_read(REG_DROP, e);
        chk("drop", e, d + 32'h1);
        send("A032_OUT_SP_00 -5");
        chk("resync", cmd_o.value, 24'hFFFE0C);
        chk("wr_485", n_wr, 4);
    endtask

    // power loss mid-run: settings rewritten over the register bus, the unit waits for a fresh start
    task automatic t_power();
        logic [31:0] d;
        logic [31:0] e;
        @(posedge sys_clk);
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
        cyc(1);
        chk("rst_cfg", nv_cfg, 14'h0);
        chk("rst_stop", remote_stop, 0);
        reg_write(REG_ADDR, 32'h00000020);
        reg_write(REG_CTRL, 32'h0000000F);
        reg_read(REG_ADDR, d);
        chk("addr", d, 32'h00000020);
        reg_read(REG_CTRL, d);
        chk("ctrl", d, 32'h0000000F);
        chk("stopped", remote_stop, 1);
        // host resends start and set values
        send("A032_OUT_MODE_05 1");
        chk("restart", remote_stop, 0);
        // temperature sent in the unit the device shows
        send("A032_OUT_SP_00 55.5");
        chk("resend", cmd_o.value, 24'h0015AE);
        send("A032_OUT_MODE_05 0");
        chk("stop", remote_stop, 1);
        reg_read(REG_DROP, d);
        send("A032_OUT_SP_00");
        send("A032_SET_SP_00 1");
        reg_read(REG_DROP, e);
        chk("drop_class", e, d + 32'h2);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog at 50000 cycles, well above the roughly one thousand cycles the tests need
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, nv_load, slow} = '0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        rx_i = '0;
        resp_i = '0;
        nv_cfg_in = CFG_RST;
        cyc(20);
        rst <= 1'b0;
        t_regs();
        t_write();
        t_block();
        t_read();
        t_485();
        t_power();
        end_sim();
    end
endmodule
